// *** rtl/psfi_defines.svh ***
// Constants of the potentiometer serial frame interface
`ifndef PSFI_DEFINES_SVH
`define PSFI_DEFINES_SVH
`define PSFI_WORD_W      16
`define PSFI_CMD_MSB     13
`define PSFI_CMD_LSB     10
`define PSFI_DATA_W      10
`define PSFI_CTRL_W      4
`define PSFI_FUSE_DEPTH  20
`define PSFI_CMD_NOP     4'h0
`define PSFI_CMD_WR_WIP  4'h1
`define PSFI_CMD_RD_WIP  4'h2
`define PSFI_CMD_STORE   4'h3
`define PSFI_CMD_REFR    4'h4
`define PSFI_CMD_RD_FUSE 4'h5
`define PSFI_CMD_WR_CTRL 4'h6
`define PSFI_CMD_RD_CTRL 4'h7
`define PSFI_CMD_SHDN    4'h8
`define PSFI_WIPER_RST   10'h200
`define PSFI_CTRL_RST    4'h0
`define PSFI_CLK_NS      40
`define PSFI_STORE_NS    6000000
`define PSFI_STORE_CYC   (`PSFI_STORE_NS / `PSFI_CLK_NS)
`endif

// *** rtl/psfi_pkg.sv ***
// Types of the potentiometer serial frame interface
package psfi_pkg;
    typedef logic [15:0] psfi_word_t;
    typedef logic [9:0]  psfi_data_t;
    typedef enum logic [1:0]
    {
        PSFI_IDLE  = 2'b00,
        PSFI_STORE = 2'b01
    } psfi_state_t;
endpackage

// *** rtl/psfi_top.sv ***
// Serial frame interface of a single-channel digital potentiometer
//
// Summary of operation
// RULE1: A sixteen-bit shift register receives each command frame.
// RULE2: Data input is sampled on every falling serial clock edge; the code skips the edges of frames that start during a store.
// RULE3: Host keeps the serial clock at or below 50 MHz.
// RULE4: Frame-sync low opens a frame and enables shifting.
// RULE5: Frame-sync rise after sixteen clocks decodes and applies the word.
// RULE6: Frame-sync rise before sixteen clocks aborts; nothing changes.
// RULE7: Serial output is open-drain, only pulls low or releases.
// RULE8: Shift register drives serial output for readback and daisy chain.
// RULE9: Active-high open-drain ready output marks finished operations.
// RULE10: Word is MSB first: two zeros, four command bits, ten data bits.
// RULE11: Bits are counted in multiples of sixteen per frame.
// RULE12: Command field selects nop, wiper, fuse, control and shutdown ops.
// RULE13: A fuse store of about 6 ms locks the shift register.
// RULE14: Bit counter realigns at the start of every new frame.
`timescale 1ns/1ps
`include "psfi_defines.svh"
module psfi_top
#(
    parameter int unsigned STORE_CYC = `PSFI_STORE_CYC
)
(
    // System clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    // Serial link from the host
    input  wire logic                sclk,
    input  wire logic                sync_n_i,
    input  wire logic                din_i,
    // Open-drain serial output
    output logic                     serial_out_o,
    output logic                     serial_out_oe_o,
    // Open-drain ready output
    output logic                     ready_o,
    output logic                     ready_oe_o,
    // Potentiometer state
    output psfi_pkg::psfi_data_t     wiper_register_o,
    output logic [`PSFI_CTRL_W-1:0]  ctrl_o,
    output logic                     shutdown_o
);
    import psfi_pkg::*;

    // ************************************************************
    // Link side, falling edges of the serial clock
    // ************************************************************
    psfi_word_t  shift_q;
    logic [3:0]  cnt_q;
    logic        seen16_q;
    logic        armed_q;
    logic        lock_q;
    logic        shift_en;
    logic        rseen_q;
    logic        sdo_oe_q;
    logic        busy_q;
    logic        rtgl_q;
    psfi_word_t  resp_q;

    // Armed while frame-sync is high, first edge of a frame clears it
    always_ff @(negedge sclk or posedge sync_n_i)
    begin
        if (sync_n_i)
            armed_q <= 1'b1; // RULE14
        else
            armed_q <= 1'b0;
    end

    // Store lock and read toggle are quasi-static: they are set a few clk_sys
    // cycles after frame-sync rises, the host keeps it high longer than that,
    // and the lock clears STORE_CYC cycles later. The serial clock stops between frames, so a
    // synchroniser on it would lag a whole frame behind.
    assign shift_en = armed_q ? !busy_q : !lock_q; // RULE13

    // Shift register and frame bit counter, lock taken at frame start
    always_ff @(negedge sclk or negedge rstn)
    begin
        if (!rstn)
        begin
            shift_q  <= '0;
            cnt_q    <= 4'h0;
            seen16_q <= 1'b0;
            rseen_q  <= 1'b0;
            sdo_oe_q <= 1'b0;
            lock_q   <= 1'b0;
        end
        else if (!sync_n_i) // RULE4
        begin
            if (armed_q)
            begin
                lock_q   <= busy_q; // RULE13
                cnt_q    <= busy_q ? 4'h0 : 4'h1; // RULE14
                seen16_q <= 1'b0;
                if (!busy_q && rtgl_q != rseen_q)
                begin
                    shift_q  <= {resp_q[14:0], din_i}; // RULE8
                    sdo_oe_q <= ~resp_q[14];
                    rseen_q  <= rtgl_q;
                end
                else if (!busy_q)
                begin
                    shift_q  <= {shift_q[14:0], din_i}; // RULE2
                    sdo_oe_q <= ~shift_q[14];
                end
            end
            else if (!lock_q)
            begin
                cnt_q    <= cnt_q + 4'h1; // RULE11
                if (cnt_q == 4'hF)
                    seen16_q <= 1'b1;
                shift_q  <= {shift_q[14:0], din_i}; // RULE1 RULE2
                sdo_oe_q <= ~shift_q[14]; // RULE8
            end
        end
    end

    // Pin never driven high, only pulled low
    assign serial_out_o    = 1'b0; // RULE7
    assign serial_out_oe_o = sdo_oe_q; // RULE7

    // ************************************************************
    // System side, frame end detection and decode
    // ************************************************************
    logic        sy1_q;
    logic        sy2_q;
    logic        sy3_q;
    logic        rise;
    logic        frame_ok;
    logic [3:0]  cmd;
    psfi_data_t  data;
    psfi_state_t state_q;
    logic [31:0] busy_cnt_q;
    logic        ready_q;
    psfi_data_t  fuse_mem [`PSFI_FUSE_DEPTH];
    logic [4:0]  fuse_n_q;
    psfi_data_t  fuse_last;

    // Frame-sync synchroniser with rising edge detect
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sy1_q <= 1'b1;
            sy2_q <= 1'b1;
            sy3_q <= 1'b1;
        end
        else
        begin
            sy1_q <= sync_n_i;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
        end
    end

    // Word and counter stand still while frame-sync is high
    assign rise      = sy2_q && !sy3_q;
    assign frame_ok  = seen16_q && (cnt_q == 4'h0)
                       && (shift_q[15:14] == 2'b00); // RULE6 RULE10
    assign cmd       = shift_q[`PSFI_CMD_MSB:`PSFI_CMD_LSB]; // RULE10
    assign data      = shift_q[`PSFI_DATA_W-1:0];
    assign fuse_last = (fuse_n_q == 5'h00) ? psfi_data_t'(`PSFI_WIPER_RST)
                       : fuse_mem[fuse_n_q - 5'h01];

    // Command decode and register update
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            wiper_register_o <= `PSFI_WIPER_RST;
            ctrl_o           <= `PSFI_CTRL_RST;
            shutdown_o       <= 1'b0;
            resp_q           <= '0;
            rtgl_q           <= 1'b0;
        end
        else if (rise && frame_ok && state_q == PSFI_IDLE) // RULE5 RULE6
        begin
            case (cmd) // RULE12
                `PSFI_CMD_WR_WIP:
                    wiper_register_o <= data;
                `PSFI_CMD_RD_WIP:
                begin
                    resp_q <= {6'h00, wiper_register_o};
                    rtgl_q <= ~rtgl_q;
                end
                `PSFI_CMD_REFR:
                    wiper_register_o <= fuse_last;
                `PSFI_CMD_RD_FUSE:
                begin
                    if (data[4:0] < 5'(`PSFI_FUSE_DEPTH))
                        resp_q <= {6'h00, fuse_mem[data[4:0]]};
                    else
                        resp_q <= {11'h000, fuse_n_q};
                    rtgl_q <= ~rtgl_q;
                end
                `PSFI_CMD_WR_CTRL:
                    ctrl_o <= data[`PSFI_CTRL_W-1:0];
                `PSFI_CMD_RD_CTRL:
                begin
                    resp_q <= {12'h000, ctrl_o};
                    rtgl_q <= ~rtgl_q;
                end
                `PSFI_CMD_SHDN:
                    shutdown_o <= data[0];
                default:
                    shutdown_o <= shutdown_o;
            endcase
        end
    end

    // Fuse memory entries, one written per store until all 20 are used
    always_ff @(posedge clk_sys)
    begin
        if (rise && frame_ok && state_q == PSFI_IDLE
            && cmd == `PSFI_CMD_STORE
            && fuse_n_q < 5'(`PSFI_FUSE_DEPTH))
            fuse_mem[fuse_n_q] <= wiper_register_o;
    end

    // Store sequencer with lock and ready
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q    <= PSFI_IDLE;
            busy_cnt_q <= 32'h0000_0000;
            busy_q     <= 1'b0;
            ready_q    <= 1'b1;
            fuse_n_q   <= 5'h00;
        end
        else
        begin
            case (state_q)
                PSFI_IDLE:
                begin
                    if (rise && frame_ok && cmd == `PSFI_CMD_STORE)
                    begin
                        state_q    <= PSFI_STORE;
                        busy_cnt_q <= 32'(STORE_CYC);
                        busy_q     <= 1'b1; // RULE13
                        ready_q    <= 1'b0;
                        if (fuse_n_q < 5'(`PSFI_FUSE_DEPTH))
                            fuse_n_q <= fuse_n_q + 5'h01;
                    end
                end
                PSFI_STORE:
                begin
                    busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
                    if (busy_cnt_q == 32'h0000_0001)
                    begin
                        state_q <= PSFI_IDLE;
                        busy_q  <= 1'b0;
                        ready_q <= 1'b1; // RULE9
                    end
                end
                default:
                    state_q <= PSFI_IDLE;
            endcase
        end
    end

    // Open-drain ready pin pulled low while busy
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ready_o    <= 1'b0;
            ready_oe_o <= 1'b0;
        end
        else
        begin
            ready_o    <= 1'b0;
            ready_oe_o <= ~ready_q; // RULE9
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_accept;
        rise && frame_ok && state_q == PSFI_IDLE;
    endsequence

    sequence s_store_start;
        s_accept ##0 (cmd == `PSFI_CMD_STORE);
    endsequence

    AST_SHIFT_IN: assert property ( // RULE2
        @(negedge sclk) disable iff (!rstn)
        (!sync_n_i && shift_en) |=> shift_q[0] == $past(din_i))
        else $error("shift register missed the data bit");

    AST_COUNT16: assert property ( // RULE11
        @(negedge sclk) disable iff (!rstn)
        (!sync_n_i && shift_en && !armed_q && cnt_q == 4'hF)
        |=> seen16_q && cnt_q == 4'h0)
        else $error("sixteenth bit not counted");

    AST_REALIGN: assert property ( // RULE14
        @(negedge sclk) disable iff (!rstn)
        (!sync_n_i && shift_en && armed_q) |=> cnt_q == 4'h1 && !seen16_q)
        else $error("frame start did not realign counter");

    AST_LOCK: assert property ( // RULE13
        @(negedge sclk) disable iff (!rstn)
        (!sync_n_i && !shift_en) |=> $stable(shift_q))
        else $error("shift register moved while locked");

    AST_ABORT: assert property ( // RULE6
        (rise && !frame_ok && state_q == PSFI_IDLE) |=> $stable(wiper_register_o)
        && $stable(ctrl_o) && $stable(shutdown_o) && ready_q == $past(ready_q))
        else $error("aborted frame changed state");

    AST_WIPER_WR: assert property ( // RULE5
        (s_accept ##0 cmd == `PSFI_CMD_WR_WIP)
        |=> wiper_register_o == $past(data))
        else $error("wiper write not applied");

    AST_REFRESH: assert property ( // RULE12
        (s_accept ##0 cmd == `PSFI_CMD_REFR)
        |=> wiper_register_o == $past(fuse_last))
        else $error("refresh did not load fuse value");

    AST_STORE_BUSY: assert property ( // RULE13
        s_store_start |=> (!ready_q && busy_q) [*8])
        else $error("store did not hold ready low");

    AST_STORE_END: assert property ( // RULE9
        (state_q == PSFI_STORE && busy_cnt_q == 32'h0000_0001)
        |=> ready_q ##1 !ready_oe_o)
        else $error("ready not restored after store");

    AST_SDO_OD: assert property ( // RULE7
        @(negedge sclk) disable iff (!rstn)
        serial_out_o == 1'b0)
        else $error("serial output driven high");
endmodule

// *** tb/psfi_host.sv ***
// Serial host model that sends frames and captures the open-drain reply
`timescale 1ns/1ps
module psfi_host
(
    // Serial link towards the device
    output logic        sclk,
    output logic        sync_n,
    output logic        din,
    // Pulled-up serial return line
    input  wire logic   sdo_pin
);
    logic [31:0] rd;

    // Clock stands high and sync stays inactive between frames
    initial
    begin
        sclk   = 1'b1;
        sync_n = 1'b1;
        din    = 1'b0;
        rd     = 32'h0;
    end

    // One frame of n bits, MSB first, 48 ns serial period
    task automatic send(input logic [31:0] w, input int n);
        #207;                               // Gap, phase apart from clk_sys
        sync_n = 1'b0;
        rd = 32'h0;
        for (int i = n - 1; i >= 0; i--)
        begin
            din = w[i];
            #24 sclk = 1'b0;
            #20 rd = {rd[30:0], sdo_pin};
            #4 sclk = 1'b1;
        end
        #24 sync_n = 1'b1;
        din = ~din;                         // Released line shows no stale bit
    endtask
endmodule

// *** tb/tb.sv ***
// Self-checking testbench of the potentiometer serial frame interface
`timescale 1ns/1ps
module tb;
    import psfi_pkg::*;
    typedef struct packed
    {
        logic [15:0] w;
        logic [9:0]  wip;
        logic [3:0]  c;
        logic        s;
    } psfi_row_t;

    logic        clk_sys;
    logic        rstn;
    logic        sclk;
    logic        sync_n;
    logic        din;
    logic        serial_out;
    logic        serial_out_oe;
    logic        ready;
    logic        ready_oe;
    logic        shdn;
    psfi_data_t  wiper;
    logic [3:0]  ctrl;
    int          num_errors;
    int          total_checks;
    int          cnt;
    wire         sdo_pin = serial_out_oe ? serial_out : 1'b1;
    psfi_row_t   rows [8] = '{
        '{16'h0555, 10'h155, 4'h0, 1'b0}, '{16'h07FF, 10'h3FF, 4'h0, 1'b0},
        '{16'h0400, 10'h000, 4'h0, 1'b0}, '{16'h180A, 10'h000, 4'hA, 1'b0},
        '{16'h2001, 10'h000, 4'hA, 1'b1}, '{16'h2000, 10'h000, 4'hA, 1'b0},
        '{16'h0000, 10'h000, 4'hA, 1'b0}, '{16'hC5AA, 10'h000, 4'hA, 1'b0}};

    psfi_top #(.STORE_CYC(60)) uut
    (
        .clk_sys          (clk_sys),
        .rstn             (rstn),
        .sclk             (sclk),
        .sync_n_i         (sync_n),
        .din_i            (din),
        .serial_out_o     (serial_out),
        .serial_out_oe_o  (serial_out_oe),
        .ready_o          (ready),
        .ready_oe_o       (ready_oe),
        .wiper_register_o (wiper),
        .ctrl_o           (ctrl),
        .shutdown_o       (shdn)
    );

    psfi_host host
    (
        .sclk    (sclk),
        .sync_n  (sync_n),
        .din     (din),
        .sdo_pin (sdo_pin)
    );

    // System clock, 40 ns
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ************************************************
    // Helpers
    // ************************************************
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask

    task automatic st(input logic [9:0] w, input logic [3:0] c, input logic s);
        chk("wiper", {6'h00, w}, {6'h00, wiper});
        chk("ctrl", {12'h000, c}, {12'h000, ctrl});
        chk("shutdown", {15'h0000, s}, {15'h0000, shdn});
        chk("pins", 16'h0000, {13'h0000, serial_out, ready, ready_oe});
    endtask

    // Frame, then the fixed decode delay of the link crossing
    task automatic frame(input logic [31:0] w, input int n);
        host.send(w, n);
        repeat (6) @(negedge clk_sys);
    endtask

    task automatic close_out;
        if (num_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ************************************************
    // Main sequence
    // ************************************************
    initial
    begin
        rstn = 1'b1;
        #1 rstn = 1'b0;
        num_errors = 0;
        total_checks = 0;
        cnt = 0;
        repeat (16) @(negedge clk_sys);
        st(10'h200, 4'h0, 1'b0);
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        foreach (rows[i])
        begin
            frame({16'h0000, rows[i].w}, 16);
            st(rows[i].wip, rows[i].c, rows[i].s);
        end
        frame(32'h0555, 10);
        st(10'h000, 4'hA, 1'b0);
        frame(32'h044406AA, 32);
        chk("wiper", 16'h02AA, {6'h00, wiper});
        chk("daisy", 16'h0444, host.rd[16:1]);
        frame(32'h0800, 16);
        frame(32'h0000, 16);
        chk("read wiper", 16'h02AA, {1'b0, host.rd[15:1]});
        frame(32'h1C00, 16);
        frame(32'h0000, 16);
        chk("read ctrl", 16'h000A, {1'b0, host.rd[15:1]});
        host.send(32'h0C00, 16);
        fork
            begin
                for (int k = 0; k < 20 && ready_oe !== 1'b1; k++)
                    @(negedge clk_sys);
                while (ready_oe === 1'b1 && cnt < 200)
                begin
                    cnt++;
                    @(negedge clk_sys);
                end
            end
            host.send(32'h0555, 16);
        join
        repeat (6) @(negedge clk_sys);
        chk("busy cycles", 16'd60, cnt[15:0]);
        st(10'h2AA, 4'hA, 1'b0);
        frame(32'h0523, 16);
        frame(32'h1000, 16);
        chk("refresh", 16'h02AA, {6'h00, wiper});
        frame(32'h1414, 16);
        frame(32'h0000, 16);
        chk("fuse status", 16'h0001, {1'b0, host.rd[15:1]});
        rstn = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("oe", 16'h0000, {14'h0000, serial_out_oe, ready_oe});
        st(10'h200, 4'h0, 1'b0);
        rstn = 1'b1;
        repeat (3) @(negedge clk_sys);
        st(10'h200, 4'h0, 1'b0);
        close_out();
    end
endmodule
